// ==== src/preic_defs.vh ====
// Offsets, field positions, reset values, event bits and AXI responses for the page request event block
`ifndef PREIC_DEFS_VH
`define PREIC_DEFS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PREIC_OFF_WAITING 8'hdc
`define PREIC_OFF_CONTROL 8'he0
`define PREIC_OFF_DATA 8'he4
`define PREIC_OFF_ADDR 8'he8
`define PREIC_OFF_UADDR 8'hec
`define PREIC_OFF_ISTAT 8'hf0
`define PREIC_OFF_IMASK 8'hf4
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PREIC_BIT_MASK 31
`define PREIC_BIT_PEND 30
`define PREIC_BIT_WAITING 0
`define PREIC_RST_MASK 1'b1
`define PREIC_RST_RSVD 30'h0000_0000
`define PREIC_RST_WORD 32'h0000_0000
`define PREIC_RST_IMASK 2'h3
// ----------------------------------------------------------------
// Event bits of the block status register
// ----------------------------------------------------------------
`define PREIC_EV_SENT 0
`define PREIC_EV_ADDED 1
// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define PREIC_RESP_OKAY 2'h0
`define PREIC_RESP_SLVERR 2'h2
`endif

// ==== src/preic_ctrl.v ====
// Page request event interrupt control with AXI4-Lite register slave
// Summary of operation
// - No capability: control reads zero, writes ignored
// - Unmasked condition sends message from data/address
// - Mask bit resets to one
// - Mask set: never send message
// - Pending set on new entry setting waiting
// - Entry while waiting set: no condition
// - Pending held while message withheld
// - Pending clears when held message sent
// - Pending clears when waiting bit serviced
// - Entry sets waiting; software writes one clears
// - Message data from data field 15:0
// - Message address from address bits 31:2
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "preic_defs.vh"
module preic_ctrl (
	input wire aclk,
	input wire aresetn,
	input wire page_request_capability,
	input wire entry_added,
	input wire send_blocked,
	input wire msg_ready,
	output reg msg_valid,
	output reg [15:0] msg_data,
	output reg [31:0] msg_addr,
	output reg [31:0] msg_uaddr,
	output reg irq,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function [31:0] strb_merge;
	input [31:0] old_v;
	input [31:0] new_v;
	input [3:0] strb;
	integer i;
	begin
		for (i = 0; i < 4; i = i + 1) begin
			strb_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
	end
endfunction

// Unmapped addresses answer with an error and change nothing
function mapped;
	input [7:0] a;
	begin
		mapped = (a == `PREIC_OFF_WAITING) || (a == `PREIC_OFF_CONTROL) ||
			(a == `PREIC_OFF_DATA) || (a == `PREIC_OFF_ADDR) ||
			(a == `PREIC_OFF_UADDR) || (a == `PREIC_OFF_ISTAT) ||
			(a == `PREIC_OFF_IMASK);
	end
endfunction

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg mask_q;
reg pend_q;
reg [29:0] rsvd_q;
reg waiting_q;
reg [31:0] data_q;
reg [29:0] addr_q;
reg [31:0] uaddr_q;
reg [1:0] istat_q;
reg [1:0] imask_q;
reg [7:0] aw_q;
reg aw_have_q;
reg [31:0] w_q;
reg [3:0] ws_q;
reg w_have_q;

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
// Event registers vanish without capability; status and mask stay live
// Write effects act on the beat pair held in aw_q and w_q
wire sel_wait = (aw_q == `PREIC_OFF_WAITING) && page_request_capability;
wire sel_ctrl = (aw_q == `PREIC_OFF_CONTROL) && page_request_capability;
wire sel_data = (aw_q == `PREIC_OFF_DATA) && page_request_capability;
wire sel_addr = (aw_q == `PREIC_OFF_ADDR) && page_request_capability;
wire sel_uaddr = (aw_q == `PREIC_OFF_UADDR) && page_request_capability;
wire sel_istat = (aw_q == `PREIC_OFF_ISTAT);
wire sel_imask = (aw_q == `PREIC_OFF_IMASK);

wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
wire [31:0] wmask = strb_merge(32'h0000_0000, 32'hffff_ffff, ws_q);
wire [31:0] wbits = w_q & wmask;
wire wr_ctrl = do_write && sel_ctrl;
wire wr_wait = do_write && sel_wait;
wire wr_data = do_write && sel_data;
wire wr_addr = do_write && sel_addr;
wire wr_uaddr = do_write && sel_uaddr;
wire wr_imask = do_write && sel_imask;
wire [1:0] ist_clr = {2{do_write && sel_istat}} & wbits[1:0];
wire [31:0] addr_merged = strb_merge({addr_q, 2'b00}, w_q, ws_q);
// Servicing the waiting bit means clearing it by a write of one
wire service = wr_wait && wbits[`PREIC_BIT_WAITING] && waiting_q;
// Rising edge of the waiting bit is the only new condition
wire new_cond = entry_added && !waiting_q && page_request_capability;
wire mask_d = wr_ctrl && ws_q[3] ? w_q[`PREIC_BIT_MASK] : mask_q;
// A message goes out only when unmasked and nothing transient blocks it
wire fire = pend_q && !mask_q && !send_blocked && !msg_valid && !service;
wire msg_done = msg_valid && msg_ready;

// ----------------------------------------------------------------
// Write channels
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		aw_q <= 8'h00;
		aw_have_q <= 1'b0;
		w_q <= `PREIC_RST_WORD;
		ws_q <= 4'h0;
		w_have_q <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `PREIC_RESP_OKAY;
	end else begin
		// Readies pulse for one cycle so each beat is taken once
		s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
		s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_q <= s_axi_awaddr;
			aw_have_q <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_q <= s_axi_wdata;
			ws_q <= s_axi_wstrb;
			w_have_q <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(aw_q) ? `PREIC_RESP_OKAY : `PREIC_RESP_SLVERR;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// Control register
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		mask_q <= `PREIC_RST_MASK;
		rsvd_q <= `PREIC_RST_RSVD;
	end else begin
		// Only the mask bit is writable
		mask_q <= mask_d;
		rsvd_q <= rsvd_q;
	end
end

// ----------------------------------------------------------------
// Message data, address and interrupt mask registers
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		data_q <= `PREIC_RST_WORD;
	end else if (wr_data) begin
		// Whole word stored; only the low half goes into a message
		data_q <= strb_merge(data_q, w_q, ws_q);
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		addr_q <= 30'h0000_0000;
	end else if (wr_addr) begin
		// Low two bits are not stored, so the address stays dword aligned
		addr_q <= addr_merged[31:2];
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		uaddr_q <= `PREIC_RST_WORD;
	end else if (wr_uaddr) begin
		// Upper address rides along unchanged with each message
		uaddr_q <= strb_merge(uaddr_q, w_q, ws_q);
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		imask_q <= `PREIC_RST_IMASK;
	end else if (wr_imask) begin
		imask_q <= wbits[1:0] | (imask_q & ~wmask[1:0]);
	end
end

// ----------------------------------------------------------------
// Waiting status bit
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		waiting_q <= 1'b0;
	// Set on entry wins over write-one clear
	end else if (entry_added && page_request_capability) begin
		waiting_q <= 1'b1;
	end else if (service) begin
		waiting_q <= 1'b0;
	end
end

// ----------------------------------------------------------------
// Pending flag
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		pend_q <= 1'b0;
	// New condition only on waiting rising
	end else if (new_cond) begin
		pend_q <= 1'b1;
	end else if (service) begin
		pend_q <= 1'b0;
	// Cleared once the message is issued
	end else if (fire) begin
		pend_q <= 1'b0;
	end
end

// ----------------------------------------------------------------
// Message issue
// ----------------------------------------------------------------
// Payload is captured at issue and stands until accepted, so later
// register writes cannot tear a message in flight
always @(posedge aclk) begin
	if (!aresetn) begin
		msg_valid <= 1'b0;
		msg_data <= 16'h0000;
		msg_addr <= `PREIC_RST_WORD;
		msg_uaddr <= `PREIC_RST_WORD;
	end else if (fire) begin
		msg_valid <= 1'b1;
		msg_data <= data_q[15:0];
		msg_addr <= {addr_q, 2'b00};
		msg_uaddr <= uaddr_q;
	end else if (msg_done) begin
		msg_valid <= 1'b0;
	end
end

// ----------------------------------------------------------------
// Sticky events and interrupt line
// ----------------------------------------------------------------
// Set wins over write-one clear so no event is lost
always @(posedge aclk) begin
	if (!aresetn) begin
		istat_q <= 2'h0;
		irq <= 1'b0;
	end else begin
		// Message sent
		if (fire) begin
			istat_q[`PREIC_EV_SENT] <= 1'b1;
		end else if (ist_clr[`PREIC_EV_SENT]) begin
			istat_q[`PREIC_EV_SENT] <= 1'b0;
		end
		// New condition
		if (new_cond) begin
			istat_q[`PREIC_EV_ADDED] <= 1'b1;
		end else if (ist_clr[`PREIC_EV_ADDED]) begin
			istat_q[`PREIC_EV_ADDED] <= 1'b0;
		end
		// One cycle behind the status so irq comes straight from a flop
		irq <= |(istat_q & ~imask_q);
	end
end

// ----------------------------------------------------------------
// Read channel
// ----------------------------------------------------------------
reg [31:0] rd_word;
always @* begin
	rd_word = `PREIC_RST_WORD;
	case (s_axi_araddr)
		`PREIC_OFF_WAITING: rd_word = {31'h0000_0000, waiting_q};
		// Reserved bits read back preserved value
		`PREIC_OFF_CONTROL: rd_word = {mask_q, pend_q, rsvd_q};
		`PREIC_OFF_DATA: rd_word = data_q;
		`PREIC_OFF_ADDR: rd_word = {addr_q, 2'b00};
		`PREIC_OFF_UADDR: rd_word = uaddr_q;
		`PREIC_OFF_ISTAT: rd_word = {30'h0000_0000, istat_q};
		`PREIC_OFF_IMASK: rd_word = {30'h0000_0000, imask_q};
		default: rd_word = `PREIC_RST_WORD;
	endcase
	// Whole event register set reads zero without capability
	if (!page_request_capability && s_axi_araddr != `PREIC_OFF_ISTAT &&
		s_axi_araddr != `PREIC_OFF_IMASK) begin
		rd_word = `PREIC_RST_WORD;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= `PREIC_RST_WORD;
		s_axi_rresp <= `PREIC_RESP_OKAY;
	end else begin
		s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
		// Read data is latched at the address handshake
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= mapped(s_axi_araddr) ? `PREIC_RESP_OKAY : `PREIC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule // preic_ctrl

// ==== tb/preic_chk.sv ====
// Port assertions for the page request event block
`timescale 1ns/1ps
module preic_chk (
	input wire aclk,
	input wire aresetn,
	input wire page_request_capability,
	input wire send_blocked,
	input wire msg_ready,
	input wire msg_valid,
	input wire [15:0] msg_data,
	input wire [31:0] msg_addr,
	input wire s_axi_awready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_HOLD: assert property (msg_valid && !msg_ready |=>
		msg_valid && $stable(msg_data) && $stable(msg_addr)) else $error("message not held");
	AST_ADDR: assert property (msg_valid |-> msg_addr[1:0] == 2'h0)
		else $error("message address not aligned");
	AST_BLOCK: assert property (send_blocked && !msg_valid |=> !msg_valid)
		else $error("message sent while blocked");
	AST_NOCAP: assert property (!page_request_capability [*3] ##0 s_axi_rvalid
		|-> s_axi_rdata == 32'h0000_0000) else $error("read data without capability");
	AST_BDONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_RDONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	AST_AWPULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write address ready too long");
	AST_BRESP: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
		else $error("bad write response code");
endmodule // preic_chk

// ==== tb/preic_rx.sv ====
// Message receiver model, prompt or slow acceptance
`timescale 1ns/1ps
module preic_rx (
	input wire aclk,
	input wire slow,
	input wire msg_valid,
	input wire [15:0] msg_data,
	input wire [31:0] msg_addr,
	output logic msg_ready,
	output int n_msg,
	output logic [15:0] last_data,
	output logic [31:0] last_addr
);
	int wait_q = 0;
	initial msg_ready = 1'b0;
	initial n_msg = 0;
	// Slow mode stalls so the held message must stand
	always @(posedge aclk) begin
		wait_q <= (msg_valid && !msg_ready) ? wait_q + 1 : 0;
		msg_ready <= msg_valid && !msg_ready && (!slow || wait_q >= 3);
		if (msg_valid && msg_ready) begin
			n_msg <= n_msg + 1;
			last_data <= msg_data;
			last_addr <= msg_addr;
		end
	end
endmodule // preic_rx

// ==== tb/tb.sv ====
// Self-checking bench for the page request event block
`timescale 1ns/1ps
`include "preic_defs.vh"
module tb;
	localparam logic [7:0] A_CTL = `PREIC_OFF_CONTROL;
	localparam logic [7:0] A_WAIT = `PREIC_OFF_WAITING;
	localparam logic [7:0] A_DATA = `PREIC_OFF_DATA;
	localparam logic [7:0] A_ADR = `PREIC_OFF_ADDR;
	localparam logic [7:0] A_UADR = `PREIC_OFF_UADDR;
	localparam logic [7:0] A_IST = `PREIC_OFF_ISTAT;
	localparam logic [7:0] A_IMK = `PREIC_OFF_IMASK;
	logic aclk, aresetn, page_request_capability, entry_added, send_blocked, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire msg_ready, msg_valid, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [15:0] msg_data, last_data;
	wire [31:0] msg_addr, msg_uaddr, last_addr, s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	logic [1:0] rsp;
	int n_msg, n_mismatch, checks, cyc;
	preic_ctrl dut (
		.aclk(aclk), .aresetn(aresetn), .page_request_capability(page_request_capability),
		.entry_added(entry_added), .send_blocked(send_blocked), .msg_ready(msg_ready),
		.msg_valid(msg_valid), .msg_data(msg_data), .msg_addr(msg_addr), .msg_uaddr(msg_uaddr),
		.irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	preic_rx rx (
		.aclk(aclk), .slow(slow), .msg_valid(msg_valid), .msg_data(msg_data),
		.msg_addr(msg_addr), .msg_ready(msg_ready), .n_msg(n_msg), .last_data(last_data),
		.last_addr(last_addr));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// ------------------------------------------------
	// Bus tasks
	// ------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
	endtask
	task rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rsp = s_axi_rresp;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(s_axi_rdata, e);
	endtask
	task ev;
		entry_added <= 1'b1;
		@(posedge aclk);
		entry_added <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	task report_and_stop;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard, runs far longer than the sequence needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			report_and_stop;
		end
	end
	// ------------------------------------------------
	// Test sequence
	// ------------------------------------------------
	initial begin
		{aresetn, entry_added, send_blocked, slow, s_axi_awvalid, s_axi_wvalid} = 6'h00;
		{page_request_capability, s_axi_bready, s_axi_rready, s_axi_arvalid} = 4'he;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
		s_axi_wstrb = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(A_CTL, 32'h8000_0000);
		rc(A_WAIT, 32'h0000_0000);
		wr(A_DATA, 32'h1234_abcd);
		wr(A_ADR, 32'hfee0_0007);
		rc(A_ADR, 32'hfee0_0004);
		wr(A_UADR, 32'h0000_00a5);
		ev;
		rc(A_CTL, 32'hc000_0000);
		rc(A_WAIT, 32'h0000_0001);
		chk(n_msg, 0);
		chk(irq, 0);
		wr(A_IMK, 32'h0000_0000);
		@(posedge aclk);
		chk(irq, 1);
		wr(A_CTL, 32'h7fff_ffff);
		repeat (4) @(posedge aclk);
		chk(n_msg, 1);
		chk(last_data, 32'h0000_abcd);
		chk(last_addr, 32'hfee0_0004);
		chk(msg_uaddr, 32'h0000_00a5);
		rc(A_CTL, 32'h0000_0000);
		ev;
		rc(A_CTL, 32'h0000_0000);
		chk(n_msg, 1);
		wr(A_WAIT, 32'h0000_0001);
		rc(A_WAIT, 32'h0000_0000);
		send_blocked <= 1'b1;
		slow <= 1'b1;
		ev;
		rc(A_CTL, 32'h4000_0000);
		send_blocked <= 1'b0;
		repeat (10) @(posedge aclk);
		chk(n_msg, 2);
		rc(A_CTL, 32'h0000_0000);
		wr(A_CTL, 32'h8000_0000);
		wr(A_WAIT, 32'h0000_0001);
		ev;
		rc(A_CTL, 32'hc000_0000);
		wr(A_WAIT, 32'h0000_0001);
		rc(A_CTL, 32'h8000_0000);
		wr(A_CTL, 32'h0000_0000);
		repeat (4) @(posedge aclk);
		chk(n_msg, 2);
		rc(A_IST, 32'h0000_0003);
		wr(A_IMK, 32'h0000_0003);
		@(posedge aclk);
		chk(irq, 0);
		wr(A_IST, 32'h0000_0003);
		wr(A_IMK, 32'h0000_0000);
		@(posedge aclk);
		chk(irq, 0);
		wr(8'h40, 32'hffff_ffff);
		chk(rsp, `PREIC_RESP_SLVERR);
		rd(8'h40);
		chk(rsp, `PREIC_RESP_SLVERR);
		page_request_capability <= 1'b0;
		wr(A_DATA, 32'h0000_0000);
		rc(A_CTL, 32'h0000_0000);
		page_request_capability <= 1'b1;
		rc(A_DATA, 32'h1234_abcd);
		report_and_stop;
	end
endmodule // tb
bind preic_ctrl preic_chk chk (
	.aclk(aclk), .aresetn(aresetn), .page_request_capability(page_request_capability),
	.send_blocked(send_blocked), .msg_ready(msg_ready), .msg_valid(msg_valid),
	.msg_data(msg_data), .msg_addr(msg_addr), .s_axi_awready(s_axi_awready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
